//--- hw/usb_rd_pkg.sv
package usb_rd_pkg;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 20;
  localparam int STROBE_TIME_NS = 1500000;
  // least time, so round up
  localparam int STROBE_CYCLES  = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STB_CNT_W      = 17;

  // ------------------------------------------------------------------
  // command codes and reply fields
  // ------------------------------------------------------------------
  localparam logic [7:0] MINOR_PORTS = 8'h00;
  localparam logic [7:0] MINOR_HI    = 8'h01;
  localparam logic [7:0] MINOR_LO    = 8'h02;
  localparam logic [7:0] MINOR_BUF   = 8'h05;
  localparam logic [7:0] MINOR_PAD   = 8'h07;
  localparam logic [7:0] MINOR_EVT   = 8'h08;
  localparam logic [7:0] MINOR_SYS   = 8'h09;
  localparam logic [7:0] BUF_DEPTH   = 8'h07;
  localparam logic [7:0] BUF_OVR     = 8'hFF;
  localparam logic [7:0] OVF_SET     = 8'hFF;
  localparam logic [7:0] OVF_CLR     = 8'h00;
  localparam int RX_OVF_BIT  = 7;
  localparam int RX_FRM_BIT  = 6;
  localparam int TX_OVF_BIT  = 7;
  localparam int I2C_ERR_BIT = 4;

  // ------------------------------------------------------------------
  // bus registers
  // ------------------------------------------------------------------
  localparam logic [7:0] IRQ_STAT_OFS = 8'h00;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS   = 8'h08;
  localparam int IRQ_W       = 3;
  localparam int IRQ_REPLY   = 0;
  localparam int IRQ_BUF_OVR = 1;
  localparam int IRQ_CNT_OVF = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  typedef enum logic {ST_IDLE, ST_STROBE} state_t;

endpackage : usb_rd_pkg

//--- hw/usb_read_cmd.sv
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
module usb_read_cmd
  import usb_rd_pkg::*;
#(
  parameter int STROBE_CYC = STROBE_CYCLES
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // command in, reply out
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_minor,
  input  wire logic [7:0]  cmd_lsb,
  output logic             cmd_ready,
  output logic             reply_valid,
  output logic [63:0]      reply_data,
  // port pins
  input  wire logic [7:0]  port0_in,
  input  wire logic [7:0]  port1_in,
  output logic [7:0]       port1_out,
  output logic [7:0]       port1_oe,
  input  wire logic        buf_strobe_in,
  input  wire logic        event_in,
  // scratch pad writes
  input  wire logic        pad_wr,
  input  wire logic [2:0]  pad_idx,
  input  wire logic [7:0]  pad_data,
  // system variables
  input  wire logic [7:0]  ctrl_setting,
  input  wire logic [7:0]  clk_prescale,
  input  wire logic [7:0]  port0_pullup,
  input  wire logic [7:0]  port1_pullup,
  input  wire logic [7:0]  usb_addr,
  input  wire logic [3:0]  rx_count,
  input  wire logic        rx_ovf,
  input  wire logic        rx_frame_err,
  input  wire logic [3:0]  tx_pending,
  input  wire logic        tx_ovf,
  input  wire logic        i2c_done,
  input  wire logic        i2c_err,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // interrupt
  output logic             irq
);

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [17:0] sync1_q;
  logic [17:0] sync2_q;
  logic [1:0]  prev_q;
  logic [7:0]  p0;
  logic [7:0]  p1;
  logic        buf_ev;
  logic        evt_ev;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= {event_in, buf_strobe_in, port1_in, port0_in};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q[17:16];
    end
  end

  assign p0     = sync2_q[7:0];
  assign p1     = sync2_q[15:8];
  assign buf_ev = sync2_q[16] & ~prev_q[0];
  assign evt_ev = sync2_q[17] & ~prev_q[1];

  // ------------------------------------------------------------------
  // state declarations
  // ------------------------------------------------------------------
  state_t               state_q, state_d;
  logic [STB_CNT_W-1:0] tmr_q, tmr_d;
  logic [7:0]           p1_out_q, p1_out_d;
  logic [7:0]           p1_oe_q, p1_oe_d;
  logic                 rvalid_q, rvalid_d;
  logic [63:0]          rdata_q, rdata_d;
  logic [63:0]          reply_now;
  logic                 rd_buf;
  logic                 rd_evt;
  logic [6:0][7:0]      buf_q, buf_d;
  logic [7:0]           bstat_q, bstat_d;
  logic [7:0]           bbase;
  logic                 ovr_ev;
  logic [7:0][7:0]      pad_q, pad_d;
  logic [31:0]          cnt_q, cnt_d;
  logic                 ovf_q, ovf_d;
  logic                 cnt_ovf_ev;
  logic                 i2c_flag_q, i2c_flag_d;
  logic                 cmd_rdy_q, cmd_rdy_d;

  // ------------------------------------------------------------------
  // reply contents
  // ------------------------------------------------------------------
  always_comb begin
    case (cmd_minor)
      MINOR_PORTS: reply_now = {48'h0, p1, p0};
      MINOR_BUF:   reply_now = {buf_q, bstat_q};
      MINOR_PAD:   reply_now = pad_q;
      MINOR_EVT:   reply_now = {24'h0, (ovf_q ? OVF_SET : OVF_CLR), cnt_q};
      // serial status is only looked at, never cleared here
      MINOR_SYS:   reply_now = {3'h0, i2c_flag_q, 4'h0,
                                tx_ovf, 3'h0, tx_pending,
                                rx_ovf, rx_frame_err, 2'h0, rx_count,
                                usb_addr, port1_pullup, port0_pullup,
                                clk_prescale, ctrl_setting};
      default:     reply_now = 64'h0;
    endcase
  end

  // ------------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    tmr_d    = tmr_q;
    p1_out_d = p1_out_q;
    p1_oe_d  = p1_oe_q;
    rvalid_d = 1'b0;
    rdata_d  = rdata_q;
    rd_buf   = 1'b0;
    rd_evt   = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (cmd_valid) begin
          if ((cmd_minor == MINOR_HI || cmd_minor == MINOR_LO) && cmd_lsb != 8'h00) begin
            state_d  = ST_STROBE;
            tmr_d    = '0;
            p1_oe_d  = cmd_lsb;
            p1_out_d = (cmd_minor == MINOR_HI) ? cmd_lsb : 8'h00;
          end else begin
            // a zero pin selection answers at once with no strobe
            rvalid_d = 1'b1;
            rdata_d  = reply_now;
            rd_buf   = (cmd_minor == MINOR_BUF);
            rd_evt   = (cmd_minor == MINOR_EVT);
          end
        end
      end
      ST_STROBE: begin
        if (tmr_q == STB_CNT_W'(STROBE_CYC - 1)) begin
          rdata_d  = {56'h0, p0};
          rvalid_d = 1'b1;
          p1_oe_d  = 8'h00;
          p1_out_d = 8'h00;
          state_d  = ST_IDLE;
        end else begin
          tmr_d = tmr_q + 1'b1;
        end
      end
    endcase
    // registered so the ready output comes straight from a flop
    cmd_rdy_d = (state_d == ST_IDLE);
  end

  // ------------------------------------------------------------------
  // read buffer, scratch pad, event counter, i2c flag
  // ------------------------------------------------------------------
  // the strobe input is not shared with the serial port by this block
  always_comb begin
    buf_d   = buf_q;
    bbase   = rd_buf ? 8'h00 : bstat_q;
    bstat_d = bbase;
    ovr_ev  = 1'b0;
    // a strobe landing on the clearing read still counts
    if (buf_ev) begin
      if (bbase == BUF_DEPTH || bbase == BUF_OVR) begin
        bstat_d = BUF_OVR;
        ovr_ev  = 1'b1;
      end else begin
        buf_d[bbase[2:0]] = p0;
        bstat_d           = bbase + 8'h01;
      end
    end
    pad_d = pad_q;
    if (pad_wr) begin
      pad_d[pad_idx] = pad_data;
    end
    cnt_d      = rd_evt ? 32'h0 : cnt_q;
    ovf_d      = rd_evt ? 1'b0 : ovf_q;
    cnt_ovf_ev = 1'b0;
    if (evt_ev) begin
      cnt_d = cnt_d + 32'h1;
      if (cnt_d == 32'h0) begin
        ovf_d      = 1'b1;
        cnt_ovf_ev = 1'b1;
      end
    end
    i2c_flag_d = i2c_done ? i2c_err : i2c_flag_q;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      tmr_q      <= '0;
      p1_out_q   <= 8'h00;
      p1_oe_q    <= 8'h00;
      rvalid_q   <= 1'b0;
      rdata_q    <= 64'h0;
      buf_q      <= '0;
      bstat_q    <= 8'h00;
      pad_q      <= '0;
      cnt_q      <= 32'h0;
      ovf_q      <= 1'b0;
      i2c_flag_q <= 1'b0;
      cmd_rdy_q  <= 1'b1;
    end else begin
      state_q    <= state_d;
      tmr_q      <= tmr_d;
      p1_out_q   <= p1_out_d;
      p1_oe_q    <= p1_oe_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      buf_q      <= buf_d;
      bstat_q    <= bstat_d;
      pad_q      <= pad_d;
      cnt_q      <= cnt_d;
      ovf_q      <= ovf_d;
      i2c_flag_q <= i2c_flag_d;
      cmd_rdy_q  <= cmd_rdy_d;
    end
  end

  // ------------------------------------------------------------------
  // ahb-lite registers and interrupt
  // ------------------------------------------------------------------
  logic             ap;
  logic             dp_wr_q, dp_wr_d;
  logic [7:0]       dp_addr_q, dp_addr_d;
  logic [IRQ_W-1:0] istat_q, istat_d;
  logic [IRQ_W-1:0] imask_q, imask_d;
  logic [IRQ_W-1:0] iev;
  logic [31:0]      hrdata_q, hrdata_d;
  logic             irq_q, irq_d;
  logic             rdy_q;

  assign ap = hsel & hready & htrans[1];

  always_comb begin
    dp_wr_d   = ap & hwrite;
    dp_addr_d = haddr[7:0];
    iev       = '0;
    iev[IRQ_REPLY]   = rvalid_d;
    iev[IRQ_BUF_OVR] = ovr_ev;
    iev[IRQ_CNT_OVF] = cnt_ovf_ev;
    istat_d = istat_q;
    imask_d = imask_q;
    if (dp_wr_q && dp_addr_q == IRQ_STAT_OFS) begin
      istat_d = istat_q & ~hwdata[IRQ_W-1:0];
    end
    if (dp_wr_q && dp_addr_q == IRQ_MASK_OFS) begin
      imask_d = hwdata[IRQ_W-1:0];
    end
    // new events beat a write-one clear in the same cycle
    istat_d  = istat_d | iev;
    irq_d    = |(istat_d & imask_d);
    // read data from next values so a read right after a write sees it
    hrdata_d = 32'h0;
    if (ap && !hwrite) begin
      case (haddr[7:0])
        IRQ_STAT_OFS: hrdata_d = {29'h0, istat_d};
        IRQ_MASK_OFS: hrdata_d = {29'h0, imask_d};
        STATUS_OFS:   hrdata_d = {16'h0, bstat_d, 6'h0, ovf_d, state_d == ST_STROBE};
        default:      hrdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dp_wr_q   <= 1'b0;
      dp_addr_q <= 8'h00;
      istat_q   <= '0;
      imask_q   <= IRQ_MASK_RST;
      hrdata_q  <= 32'h0;
      irq_q     <= 1'b0;
      rdy_q     <= 1'b1;
    end else begin
      dp_wr_q   <= dp_wr_d;
      dp_addr_q <= dp_addr_d;
      istat_q   <= istat_d;
      imask_q   <= imask_d;
      hrdata_q  <= hrdata_d;
      irq_q     <= irq_d;
      rdy_q     <= 1'b1;
    end
  end

  assign cmd_ready   = cmd_rdy_q;
  assign reply_valid = rvalid_q;
  assign reply_data  = rdata_q;
  assign port1_out   = p1_out_q;
  assign port1_oe    = p1_oe_q;
  assign hreadyout   = rdy_q;
  assign hresp       = 1'b0;
  assign hrdata      = hrdata_q;
  assign irq         = irq_q;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic acc;
  assign acc = cmd_valid && state_q == ST_IDLE;

  AST_PORT_READ: assert property (
    acc && cmd_minor == MINOR_PORTS |=> reply_valid && reply_data[15:0] == $past({p1, p0}))
    else $error("port read reply wrong");
  AST_HI_STROBE: assert property (
    acc && cmd_minor == MINOR_HI && cmd_lsb != 8'h00
      |=> port1_oe == $past(cmd_lsb) && port1_out == $past(cmd_lsb))
    else $error("high strobe not driven");
  AST_LO_STROBE: assert property (
    acc && cmd_minor == MINOR_LO && cmd_lsb != 8'h00
      |=> port1_oe == $past(cmd_lsb) && port1_out == 8'h00)
    else $error("low strobe not driven");
  AST_STROBE_SEQ: assert property (
    state_q == ST_STROBE && state_d == ST_IDLE
      |=> reply_valid && port1_oe == 8'h00 && reply_data[7:0] == $past(p0))
    else $error("strobe end sequence wrong");
  AST_STROBE_OFF: assert property (
    acc && (cmd_minor == MINOR_HI || cmd_minor == MINOR_LO) && cmd_lsb == 8'h00
      |=> reply_valid && port1_oe == 8'h00 && cmd_ready)
    else $error("disabled strobe read misbehaved");
  AST_BUF_REPLY: assert property (
    acc && cmd_minor == MINOR_BUF |=> reply_data[7:0] == $past(bstat_q))
    else $error("buffer status not returned");
  AST_BUF_OVR: assert property (
    buf_ev && !rd_buf && bstat_q == BUF_DEPTH |=> bstat_q == BUF_OVR && $stable(buf_q))
    else $error("overrun not flagged");
  AST_BUF_CLR: assert property (
    rd_buf && !buf_ev |=> bstat_q == 8'h00)
    else $error("buffer status not cleared");
  AST_CNT_CLR: assert property (
    rd_evt && !evt_ev |=> cnt_q == 32'h0 && !ovf_q)
    else $error("event counter not cleared");
  AST_CNT_OVF: assert property (
    evt_ev && !rd_evt && cnt_q == 32'hFFFFFFFF |=> ovf_q ##1 (acc && cmd_minor == MINOR_EVT)
      |=> reply_data[39:32] == OVF_SET)
    else $error("overflow byte wrong");
  AST_I2C_FLAG: assert property (
    i2c_done |=> i2c_flag_q == $past(i2c_err))
    else $error("i2c flag not refreshed");
  AST_REPLY_ONCE: assert property (
    reply_valid |-> $past(acc) || $past(state_q == ST_STROBE))
    else $error("reply without a taken command");

  COV_STROBE: cover property (acc && cmd_minor == MINOR_HI && cmd_lsb != 8'h00);
  COV_BUF_OVR: cover property (ovr_ev);
  COV_CNT_OVF: cover property (cnt_ovf_ev);
  COV_IRQ: cover property (irq);

endmodule : usb_read_cmd

//--- dv/host_model.sv
`timescale 1ns/100ps
module host_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // command out, reply in
  output logic             cmd_valid,
  output logic [7:0]       cmd_minor,
  output logic [7:0]       cmd_lsb,
  input  wire logic        cmd_ready,
  input  wire logic        reply_valid,
  input  wire logic [63:0] reply_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_minor = 8'h00;
    cmd_lsb   = 8'h00;
  end

  // one command at a time; buffer reads never overlap serial traffic
  task automatic send(input logic [7:0] mn, input logic [7:0] lsb,
                      output logic [63:0] rd);
    int n;
    rd = 'x;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_minor <= mn;
    cmd_lsb   <= lsb;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 200);
    cmd_valid <= 1'b0;
    // released lines must not keep looking valid
    cmd_minor <= ~mn;
    cmd_lsb   <= ~lsb;
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk);
      if (reply_valid === 1'b1 && rst === 1'b0) begin
        rd = reply_data;
        break;
      end
    end
  endtask : send
endmodule : host_model

//--- dv/test_usb_io_read_command_handler.sv
`timescale 1ns/100ps
module test_usb_io_read_command_handler;
  import usb_rd_pkg::*;

  localparam int STB = 20;

  typedef struct {
    logic [7:0]  mn;
    logic [7:0]  lsb;
    logic [63:0] exp;
  } row_t;

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid, cmd_ready, reply_valid, hreadyout, hresp, irq;
  logic [7:0]  cmd_minor, cmd_lsb, port1_out, port1_oe;
  logic [63:0] reply_data, rd;
  logic [7:0]  port0_in = 8'h5A, port1_in = 8'hC3;
  logic        buf_strobe_in = 1'b0, event_in = 1'b0, pad_wr = 1'b0;
  logic [2:0]  pad_idx = 3'h0;
  logic [7:0]  pad_data = 8'h00, ctrl_setting = 8'h11, clk_prescale = 8'h22;
  logic [7:0]  port0_pullup = 8'h33, port1_pullup = 8'h44, usb_addr = 8'h55;
  logic [3:0]  rx_count = 4'h3, tx_pending = 4'h2;
  logic        rx_ovf = 1'b1, rx_frame_err = 1'b0, tx_ovf = 1'b1;
  logic        i2c_done = 1'b0, i2c_err = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, brd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  wire         hready = hreadyout;
  logic [7:0]  seen_oe, seen_out;
  int          stb_cyc, error_cnt = 0, check_count = 0;
  row_t        rows [7];

  always #10 core_clk = ~core_clk;

  usb_read_cmd #(.STROBE_CYC(STB)) u_dut (
    .core_clk, .rst, .cmd_valid, .cmd_minor, .cmd_lsb, .cmd_ready, .reply_valid,
    .reply_data, .port0_in, .port1_in, .port1_out, .port1_oe, .buf_strobe_in,
    .event_in, .pad_wr, .pad_idx, .pad_data, .ctrl_setting, .clk_prescale,
    .port0_pullup, .port1_pullup, .usb_addr, .rx_count, .rx_ovf, .rx_frame_err,
    .tx_pending, .tx_ovf, .i2c_done, .i2c_err, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq
  );

  host_model u_host (
    .core_clk, .rst, .cmd_valid, .cmd_minor, .cmd_lsb, .cmd_ready,
    .reply_valid, .reply_data
  );

  // strobe pin watcher: width and levels of the port 1 strobe
  always @(posedge core_clk) begin
    if (port1_oe !== 8'h00) begin
      stb_cyc++;
      seen_oe  = port1_oe;
      seen_out = port1_out;
    end
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  // held long enough for the two-flop synchroniser and edge detector
  task automatic pin_pulse(input bit evt, input logic [7:0] v);
    @(posedge core_clk);
    port0_in <= v;
    if (evt) event_in <= 1'b1;
    else buf_strobe_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    event_in      <= 1'b0;
    buf_strobe_in <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : pin_pulse

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    int n;
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    r = hrdata;
    hsel <= 1'b0;
  endtask : bus

  task automatic i2c_op(input logic e);
    @(posedge core_clk);
    i2c_err  <= e;
    i2c_done <= 1'b1;
    @(posedge core_clk);
    i2c_done <= 1'b0;
  endtask : i2c_op

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    rows = '{'{8'h00, 8'h00, 64'h0000_0000_0000_C35A},
             '{8'h09, 8'h00, 64'h0082_8355_4433_2211},
             '{8'h07, 8'h00, 64'h0}, '{8'h08, 8'h00, 64'h0},
             '{8'h01, 8'h00, 64'h0}, '{8'h02, 8'h00, 64'h0},
             '{8'h03, 8'h00, 64'h0}};
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("ready after reset", 64'h1, {63'h0, cmd_ready});
    foreach (rows[i]) begin
      u_host.send(rows[i].mn, rows[i].lsb, rd);
      chk("table reply", rows[i].exp, rd);
    end
    $display("table done");

    stb_cyc = 0;
    fork
      u_host.send(MINOR_HI, 8'h08, rd);
      begin
        repeat (5) @(posedge core_clk);
        port0_in <= 8'h3C;
      end
    join
    chk("high strobe data", 64'h3C, {56'h0, rd[7:0]});
    chk("high strobe pins", 64'h0808, {48'h0, seen_oe, seen_out});
    chk("high strobe width", STB, stb_cyc);
    stb_cyc = 0;
    u_host.send(MINOR_LO, 8'h04, rd);
    chk("low strobe pins", 64'h0400, {48'h0, seen_oe, seen_out});
    chk("low strobe width", STB, stb_cyc);
    chk("strobe released", 64'h0, {56'h0, port1_oe});
    $display("strobe done");

    for (int i = 1; i <= 8; i++) pin_pulse(1'b0, 8'hA0 + i[7:0]);
    u_host.send(MINOR_BUF, 8'h00, rd);
    chk("buffer overrun", 64'hA7A6_A5A4_A3A2_A1FF, rd);
    u_host.send(MINOR_BUF, 8'h00, rd);
    chk("buffer cleared", 64'h0, {56'h0, rd[7:0]});
    pin_pulse(1'b0, 8'hB1);
    pin_pulse(1'b0, 8'hB2);
    u_host.send(MINOR_BUF, 8'h00, rd);
    chk("buffer partial", 64'hB2B102, {40'h0, rd[23:0]});
    $display("buffer done");

    for (int i = 0; i < 5; i++) pin_pulse(1'b1, 8'h00);
    u_host.send(MINOR_EVT, 8'h00, rd);
    chk("event count", 64'h5, {24'h0, rd[39:0]});
    u_host.send(MINOR_EVT, 8'h00, rd);
    chk("event cleared", 64'h0, {24'h0, rd[39:0]});
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      pad_wr   <= 1'b1;
      pad_idx  <= i[2:0];
      pad_data <= 8'h10 + i[7:0];
    end
    @(posedge core_clk);
    pad_wr <= 1'b0;
    u_host.send(MINOR_PAD, 8'h00, rd);
    chk("scratch pad", 64'h1716_1514_1312_1110, rd);
    $display("event and pad done");

    i2c_op(1'b1);
    u_host.send(MINOR_SYS, 8'h00, rd);
    chk("i2c flag set", 64'h1082_8355_4433_2211, rd);
    i2c_err <= 1'b0;
    u_host.send(MINOR_SYS, 8'h00, rd);
    chk("sys read repeat", 64'h1082_8355_4433_2211, rd);
    i2c_op(1'b0);
    u_host.send(MINOR_SYS, 8'h00, rd);
    chk("i2c flag clear", 64'h0, {56'h0, rd[63:56]});
    $display("system done");

    chk("irq masked", 64'h0, {63'h0, irq});
    bus(1'b0, 8'h00, 32'h0, brd);
    chk("irq status", 64'h3, {32'h0, brd});
    bus(1'b1, 8'h04, 32'h2, brd);
    repeat (3) @(posedge core_clk);
    chk("irq raised", 64'h1, {63'h0, irq});
    bus(1'b1, 8'h00, 32'h2, brd);
    repeat (3) @(posedge core_clk);
    chk("irq cleared", 64'h0, {63'h0, irq});
    bus(1'b0, 8'h00, 32'h0, brd);
    chk("status after clear", 64'h1, {32'h0, brd});
    bus(1'b0, 8'h04, 32'h0, brd);
    chk("mask readback", 64'h2, {32'h0, brd});
    bus(1'b0, 8'h0C, 32'h0, brd);
    chk("unmapped read", 64'h0, {32'h0, brd});
    $display("bus done");

    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("reset outputs", 64'h600, {53'h0, cmd_ready, hreadyout, irq, port1_oe});
    rst <= 1'b0;
    u_host.send(MINOR_PAD, 8'h00, rd);
    chk("pad after reset", 64'h0, rd);
    $display("reset done");
    close_out();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    close_out();
  end
endmodule : test_usb_io_read_command_handler
